// ---- rtl/dcc_pkg.sv ----
// Package holding register map, field positions and types of the channel block.
package dcc_pkg;

  // Register byte addresses chosen for this block.
  localparam logic [11:0] DCC_LITE_DEBUG_ADDR = 12'h000;
  localparam logic [11:0] DCC_FULL_CS_ADDR    = 12'h004;
  localparam logic [11:0] DCC_FULL_CFG_ADDR   = 12'h008;

  // Debug word field positions.
  localparam int DCC_DBG_LITE_BIT  = 28;
  localparam int DCC_DBG_VER_LSB   = 25;
  localparam int DCC_DBG_STATE_LSB = 16;
  localparam int DCC_DBG_ID_LSB    = 8;
  localparam int DCC_DBG_OWR_LSB   = 4;
  localparam int DCC_DBG_RDERR_BIT = 2;
  localparam int DCC_DBG_BUFERR_BIT = 1;
  localparam int DCC_DBG_LASTERR_BIT = 0;

  // Control/status word field positions.
  localparam int DCC_CS_HALT_BIT   = 31;
  localparam int DCC_CS_ABORT_BIT  = 30;
  localparam int DCC_CS_IGNDBG_BIT = 29;
  localparam int DCC_CS_WAITWR_BIT = 28;
  localparam int DCC_CS_OUTST_BIT  = 25;
  localparam int DCC_CS_BUSY_BIT   = 24;
  localparam int DCC_CS_URG_LSB    = 20;
  localparam int DCC_CS_NORM_LSB   = 16;

  // Configuration word: error reactions.
  localparam int DCC_CFG_HALTERR_BIT  = 0;
  localparam int DCC_CFG_ABORTERR_BIT = 1;

  // Constant field values and reset values.
  localparam logic       DCC_LITE_FLAG   = 1'h1;
  localparam logic [2:0] DCC_VERSION     = 3'h5; // Arbitrary version value.
  localparam logic [8:0] DCC_STATE_RESET = 9'h000;
  localparam logic [3:0] DCC_CNT_RESET   = 4'h0;
  localparam logic [3:0] DCC_WR_DEPTH    = 4'h8;
  localparam logic [3:0] DCC_RD_BURST    = 4'h4;

  // AXI response codes.
  localparam logic [1:0] DCC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DCC_RESP_SLVERR = 2'h2;

  // Channel engine states.
  typedef enum logic [8:0] {
    DCC_IDLE,
    DCC_RUN,
    DCC_DRAIN,
    DCC_WAITWR,
    DCC_NEXT
  } dcc_state_e;

  // Engine events from the data path.
  typedef struct packed {
    logic start;
    logic lenDone;
    logic wrIssue;
    logic wrResp;
    logic rdIssue;
    logic rdBeat;
    logic rdLast;
    logic rdErr;
    logic bufErr;
  } dcc_evt_s;

endpackage

// ---- rtl/dcc_channel.sv ----
// Channel control, status and debug logic with an AXI4-Lite register slave.
//
// Function
// R1: Lite debug word bit 28 reads constant one.
// R2: Debug bits 27:25 read a fixed three-bit version value.
// R3: Debug bits 24:16 show engine state, zero after reset.
// R4: Debug bits 15:8 show the channel's bus ID.
// R5: Bits 7:4 count pending write responses; cleared at transfer start.
// R6: Sticky read-response error at bit 2, write one clears.
// R7: Sticky buffer error at bit 1, write one clears.
// R8: Sticky missing-last error at bit 0, write one clears.
// R9: Halt bit 31 zeroes length, finishes transfer, drains bus.
// R10: After halt go idle, keep descriptor pointer, self-clear halt.
// R11: Halt-on-error setting sets halt bit on an error.
// R12: Abort bit 30 drains, then loads nonzero next descriptor.
// R13: Abort bit clears itself when abort finishes.
// R14: Abort-on-error setting sets abort bit on an error.
// R15: Bit 29 set ignores debug pause; clear obeys it.
// R16: While paused issue no new commands; resume in place.
// R17: Bit 28 waits for write count zero before completion.
// R18: Outstanding writes capped at internal buffer depth.
// R19: Bit 25 set when read or write counters nonzero.
// R20: Bit 24 set while channel operates or waits.
// R21: Bits 23:20 give QoS while selected panic line is one.
// R22: Software checks busy clear before gating channel clocks.
// R23: Bits 19:16 give QoS when panic is zero or none selected.
// R24: Halt and abort together act as halt only.
`timescale 1ns/1ps
module dcc_channel (
  input  wire logic               clk_sys,
  input  wire logic               srst,
  input  wire logic [11:0]        s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [11:0]        s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire dcc_pkg::dcc_evt_s  evt,
  input  wire logic [7:0]         channelBusId,
  input  wire logic [31:0]        nextDescriptorPtr,
  input  wire logic               dbgPause,
  input  wire logic               panicSel,
  input  wire logic               periphSelected,
  output logic                    issueAllow,
  output logic                    lenZero,
  output logic                    loadNext,
  output logic                    transferDone,
  output logic                    channelActive,
  output logic [31:0]             descriptorAddr,
  output logic [3:0]              axiQos
);
  import dcc_pkg::*;

  // Pause and panic come from pins: two-stage synchronisers.
  logic [1:0] pauseSync_q;
  logic [1:0] panicSync_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pauseSync_q <= 2'h0;
      panicSync_q <= 2'h0;
    end else begin
      pauseSync_q <= {pauseSync_q[0], dbgPause};
      panicSync_q <= {panicSync_q[0], panicSel};
    end
  end

  dcc_state_e state_q;
  logic       halt_q, abort_q, ignDbg_q, waitWr_q;
  logic [3:0] urgQos_q, normQos_q;
  logic       haltErr_q, abortErr_q;
  logic       rdErr_q, bufErr_q, lastErr_q;
  logic [3:0] owr_q, ord_q;
  logic [3:0] rdBeats_q;
  logic       lenZero_q;
  logic       wrEn, wrCsHit, wrDbgHit, wrCfgHit;
  logic       errEvt, paused, outstanding, lastMissing;

  // Write channel handshake: take address and data in either order.
  logic        awHeld_q, wHeld_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 12'h000;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
    end else if (wrEn) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
    end
  end

  // A write acts once both halves are held; unmapped gives SLVERR.
  assign wrEn     = awHeld_q && wHeld_q;
  assign wrCsHit  = wrEn && awAddr_q == DCC_FULL_CS_ADDR;
  assign wrDbgHit = wrEn && awAddr_q == DCC_LITE_DEBUG_ADDR;
  assign wrCfgHit = wrEn && awAddr_q == DCC_FULL_CFG_ADDR;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= DCC_RESP_OKAY;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wrCsHit || wrDbgHit || wrCfgHit) ?
                      DCC_RESP_OKAY : DCC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software-owned control fields, byte lanes honoured.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ignDbg_q   <= 1'b0;
      waitWr_q   <= 1'b0;
      urgQos_q   <= 4'h0;
      normQos_q  <= 4'h0;
      haltErr_q  <= 1'b0;
      abortErr_q <= 1'b0;
    end else begin
      if (wrCsHit && wStrb_q[3]) begin
        ignDbg_q <= wData_q[DCC_CS_IGNDBG_BIT];
        waitWr_q <= wData_q[DCC_CS_WAITWR_BIT];
      end
      if (wrCsHit && wStrb_q[2]) begin
        urgQos_q  <= wData_q[DCC_CS_URG_LSB +: 4];
        normQos_q <= wData_q[DCC_CS_NORM_LSB +: 4];
      end
      if (wrCfgHit && wStrb_q[0]) begin
        haltErr_q  <= wData_q[DCC_CFG_HALTERR_BIT];
        abortErr_q <= wData_q[DCC_CFG_ABORTERR_BIT];
      end
    end
  end

  // Missing last: the burst's final beat lacks the last flag.
  assign lastMissing = evt.rdBeat && rdBeats_q == 4'h1 && !evt.rdLast;
  assign errEvt = evt.rdErr || evt.bufErr || lastMissing;

  // Sticky error flags; a new error wins over a write-one clear.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdErr_q   <= 1'b0;
      bufErr_q  <= 1'b0;
      lastErr_q <= 1'b0;
    end else begin
      rdErr_q <= evt.rdErr || (rdErr_q && !(wrDbgHit && wStrb_q[0] && // R6
                 wData_q[DCC_DBG_RDERR_BIT]));
      bufErr_q <= evt.bufErr || (bufErr_q && !(wrDbgHit && wStrb_q[0] && // R7
                  wData_q[DCC_DBG_BUFERR_BIT]));
      lastErr_q <= lastMissing || (lastErr_q && !(wrDbgHit && // R8
                   wStrb_q[0] && wData_q[DCC_DBG_LASTERR_BIT]));
    end
  end

  // Beats left in the current read burst; rdIssue loads a burst of 4.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rdBeats_q <= DCC_CNT_RESET;
    end else if (evt.rdIssue && issueAllow) begin
      rdBeats_q <= DCC_RD_BURST;
    end else if (evt.rdBeat && rdBeats_q != 4'h0) begin
      rdBeats_q <= rdBeats_q - 4'h1;
    end
  end

  // Outstanding write responses and read bursts.
  always_ff @(posedge clk_sys) begin
    if (srst || evt.start) begin
      owr_q <= DCC_CNT_RESET; // R5
    end else begin
      case ({evt.wrIssue && issueAllow, evt.wrResp && owr_q != 4'h0})
        2'b10: owr_q <= owr_q + 4'h1; // R5
        2'b01: owr_q <= owr_q - 4'h1; // R5
        default: owr_q <= owr_q;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (srst || evt.start) begin
      ord_q <= DCC_CNT_RESET;
    end else begin
      case ({evt.rdIssue && issueAllow,
             evt.rdBeat && evt.rdLast && ord_q != 4'h0})
        2'b10: ord_q <= ord_q + 4'h1;
        2'b01: ord_q <= ord_q - 4'h1;
        default: ord_q <= ord_q;
      endcase
    end
  end
  assign outstanding = owr_q != 4'h0 || ord_q != 4'h0; // R19

  // Pause gates new commands only, so state is kept in place.
  assign paused = pauseSync_q[1] && !ignDbg_q; // R15
  assign issueAllow = state_q == DCC_RUN && !paused && !lenZero_q && // R16
                      owr_q < DCC_WR_DEPTH; // R18

  // Halt and abort: software or error sets, finishing sequence clears.
  logic stopDone;
  assign stopDone = state_q == DCC_DRAIN && !outstanding;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      halt_q  <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      if ((wrCsHit && wStrb_q[3] && wData_q[DCC_CS_HALT_BIT]) || // R9
          (errEvt && haltErr_q)) begin // R11
        halt_q <= 1'b1;
      end else if (stopDone || state_q == DCC_IDLE) begin
        halt_q <= 1'b0; // R10
      end
      if (wrCsHit && wStrb_q[3] && wData_q[DCC_CS_HALT_BIT]) begin
        abort_q <= 1'b0; // R24
      end else if ((wrCsHit && wStrb_q[3] && wData_q[DCC_CS_ABORT_BIT]) ||
                   (errEvt && abortErr_q)) begin // R14
        abort_q <= 1'b1; // R12
      end else if (stopDone || state_q == DCC_IDLE) begin
        abort_q <= 1'b0; // R13
      end
    end
  end

  // Length counters zeroed for a halt or abort, freed for a new descriptor.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lenZero_q <= 1'b0;
    end else if (evt.start || loadNext) begin
      lenZero_q <= 1'b0;
    end else if (halt_q || abort_q) begin
      lenZero_q <= 1'b1; // R9
    end
  end
  assign lenZero = lenZero_q;

  // Engine sequence.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= DCC_IDLE; // R3
    end else begin
      case (state_q)
        DCC_IDLE: if (evt.start) state_q <= DCC_RUN;
        DCC_RUN: begin
          if (halt_q || abort_q) begin
            state_q <= DCC_DRAIN; // R9
          end else if (evt.lenDone) begin
            state_q <= waitWr_q ? DCC_WAITWR : DCC_NEXT; // R17
          end
        end
        DCC_WAITWR: if (owr_q == 4'h0) state_q <= DCC_NEXT; // R17
        DCC_DRAIN: begin
          if (!outstanding) begin
            if (halt_q) begin
              state_q <= DCC_IDLE; // R10
            end else if (nextDescriptorPtr != 32'h0000_0000) begin
              state_q <= DCC_RUN; // R12
            end else begin
              state_q <= DCC_IDLE;
            end
          end
        end
        DCC_NEXT: state_q <= DCC_IDLE;
        default: state_q <= DCC_IDLE;
      endcase
    end
  end

  // Descriptor pointer keeps the aborted descriptor on halt.
  assign loadNext = stopDone && !halt_q && // R24
                    nextDescriptorPtr != 32'h0000_0000; // R12
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      descriptorAddr <= 32'h0000_0000;
    end else if (loadNext) begin
      descriptorAddr <= nextDescriptorPtr; // R12
    end
  end

  // Completion pulse and activity flag.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      transferDone <= 1'b0;
    end else begin
      transferDone <= state_q == DCC_NEXT; // R17
    end
  end
  assign channelActive = state_q != DCC_IDLE; // R10
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      axiQos <= 4'h0;
    end else if (panicSync_q[1] && periphSelected) begin
      axiQos <= urgQos_q; // R21
    end else begin
      axiQos <= normQos_q; // R23
    end
  end

  // Read channel: one read in flight, answer one cycle after address.
  logic [31:0] rdWord;
  always_comb begin
    rdWord = 32'h0000_0000;
    case (s_axi_araddr)
      DCC_LITE_DEBUG_ADDR: begin
        rdWord[DCC_DBG_LITE_BIT] = DCC_LITE_FLAG; // R1
        rdWord[DCC_DBG_VER_LSB +: 3] = DCC_VERSION; // R2
        rdWord[DCC_DBG_STATE_LSB +: 9] = state_q; // R3
        rdWord[DCC_DBG_ID_LSB +: 8] = channelBusId; // R4
        rdWord[DCC_DBG_OWR_LSB +: 4] = owr_q; // R5
        rdWord[DCC_DBG_RDERR_BIT] = rdErr_q;
        rdWord[DCC_DBG_BUFERR_BIT] = bufErr_q;
        rdWord[DCC_DBG_LASTERR_BIT] = lastErr_q;
      end
      DCC_FULL_CS_ADDR: begin
        rdWord[DCC_CS_HALT_BIT] = halt_q;
        rdWord[DCC_CS_ABORT_BIT] = abort_q;
        rdWord[DCC_CS_IGNDBG_BIT] = ignDbg_q;
        rdWord[DCC_CS_WAITWR_BIT] = waitWr_q;
        rdWord[DCC_CS_OUTST_BIT] = outstanding; // R19
        rdWord[DCC_CS_BUSY_BIT] = channelActive || outstanding; // R20
        rdWord[DCC_CS_URG_LSB +: 4] = urgQos_q;
        rdWord[DCC_CS_NORM_LSB +: 4] = normQos_q;
      end
      DCC_FULL_CFG_ADDR: begin
        rdWord[DCC_CFG_HALTERR_BIT] = haltErr_q;
        rdWord[DCC_CFG_ABORTERR_BIT] = abortErr_q;
      end
      default: rdWord = 32'h0000_0000;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= DCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdWord;
      s_axi_rresp  <= (s_axi_araddr == DCC_LITE_DEBUG_ADDR ||
                       s_axi_araddr == DCC_FULL_CS_ADDR ||
                       s_axi_araddr == DCC_FULL_CFG_ADDR) ?
                      DCC_RESP_OKAY : DCC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks on the engine behaviour.
  rd_err_sticky_a: assert property (@(posedge clk_sys) disable iff (srst) // R6
    evt.rdErr |=> rdErr_q) else $error("read error flag not set");
  wr_cap_a: assert property (@(posedge clk_sys) disable iff (srst) // R18
    owr_q <= DCC_WR_DEPTH) else $error("write count above depth");
  no_issue_pause_a: assert property (@(posedge clk_sys) disable iff (srst)
    paused |-> !issueAllow) else $error("issue while paused"); // R16
  halt_idle_a: assert property (@(posedge clk_sys) disable iff (srst) // R10
    (stopDone && halt_q) |=> state_q == DCC_IDLE && !halt_q)
    else $error("halt did not finish in idle");
  halt_no_load_a: assert property (@(posedge clk_sys) disable iff (srst)
    halt_q |-> !loadNext) else $error("halt loaded next descriptor"); // R24
  wait_wr_a: assert property (@(posedge clk_sys) disable iff (srst) // R17
    transferDone |-> $past(owr_q) == 4'h0 || !waitWr_q)
    else $error("done with writes pending");
  abort_clear_a: assert property (@(posedge clk_sys) disable iff (srst)
    (stopDone && abort_q && !halt_q && !wrCsHit && !errEvt) |=> !abort_q)
    else $error("abort did not self-clear"); // R13
  qos_sel_a: assert property (@(posedge clk_sys) disable iff (srst) // R21
    (panicSync_q[1] && periphSelected) |=> axiQos == $past(urgQos_q))
    else $error("urgent qos not applied");
  start_clr_a: assert property (@(posedge clk_sys) disable iff (srst)
    evt.start |=> owr_q == 4'h0) else $error("count not cleared"); // R5
  halt_cov: cover property (@(posedge clk_sys) stopDone && halt_q);
  abort_cov: cover property (@(posedge clk_sys) loadNext);
  wait_cov: cover property (@(posedge clk_sys) state_q == DCC_WAITWR);
endmodule

// ---- bench/dcc_far_model.sv ----
// Far-side model: data path events and the write-response return.
`timescale 1ns/1ps
module dcc_far_model (
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              issueAllow,
  input  wire dcc_pkg::dcc_evt_s evtReq,
  input  wire logic              respGo,
  output dcc_pkg::dcc_evt_s      evt,
  output logic [4:0]             pendQ
);
  import dcc_pkg::*;

  dcc_evt_s reqQ;

  // Commands leave only while the channel permits them.
  // Responses return one a cycle while respGo is high.
  always_comb begin
    evt         = reqQ;
    evt.wrIssue = reqQ.wrIssue & issueAllow;
    evt.rdIssue = reqQ.rdIssue & issueAllow;
    evt.wrResp  = respGo & (pendQ != 5'h00);
  end

  // Requests are launched a cycle late; pending writes are tallied.
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      reqQ  <= '0;
      pendQ <= 5'h00;
    end else begin
      reqQ  <= evtReq;
      pendQ <= pendQ + 5'(evt.wrIssue) - 5'(evt.wrResp);
    end
  end
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench of the channel control and debug block.
`timescale 1ns/1ps
module testbench;
  import dcc_pkg::*;

  localparam logic [7:0] BUS_ID  = 8'h5A;
  localparam logic [8:0] EV_STRT = 9'h100;
  localparam logic [8:0] EV_LEN  = 9'h080;
  localparam logic [8:0] EV_WR   = 9'h040;
  localparam logic [8:0] EV_RDI  = 9'h010;
  localparam logic [8:0] EV_BEAT = 9'h008;
  localparam logic [8:0] EV_LAST = 9'h004;
  localparam logic [8:0] EV_RERR = 9'h002;
  localparam logic [8:0] EV_BERR = 9'h001;

  typedef struct packed {
    logic [8:0]  last;
    logic [8:0]  err;
    logic [31:0] mask;
  } dcc_erow_s;
  typedef struct packed {
    logic [31:0] cs;
    logic [1:0]  cfg;
    logic [8:0]  err;
    logic        abt;
  } dcc_srow_s;

  localparam dcc_erow_s EROWS [4] = '{'{EV_LAST, EV_RERR, 32'h4},
    '{EV_LAST, EV_BERR, 32'h2}, '{9'h000, 9'h000, 32'h1},
    '{EV_LAST, 9'h000, 32'h0}};
  localparam dcc_srow_s SROWS [5] = '{'{32'h4000_0000, 2'h0, 9'h0, 1'b1},
    '{32'h0, 2'h2, EV_BERR, 1'b1}, '{32'hC000_0000, 2'h0, 9'h0, 1'b0},
    '{32'h0, 2'h1, EV_RERR, 1'b0}, '{32'h8000_0000, 2'h0, 9'h0, 1'b0}};

  logic        clk_sys, srst;
  logic [11:0] awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd, ptr, a0, descriptorAddr;
  logic [1:0]  bresp, rresp, resp;
  dcc_evt_s    evtReq, evt;
  logic        dbgPause, panicSel, periphSel, respGo;
  logic        issueAllow, lenZero, loadNext, transferDone, channelActive;
  logic [3:0]  axiQos;
  logic [4:0]  pendQ;
  int          error_cnt, total_checks, cycles, doneCnt, nextCnt, n0;

  dcc_channel u_dut (.clk_sys(clk_sys), .srst(srst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .evt(evt), .channelBusId(BUS_ID),
    .nextDescriptorPtr(ptr), .dbgPause(dbgPause), .panicSel(panicSel),
    .periphSelected(periphSel), .issueAllow(issueAllow),
    .lenZero(lenZero), .loadNext(loadNext), .transferDone(transferDone),
    .channelActive(channelActive), .descriptorAddr(descriptorAddr),
    .axiQos(axiQos));

  dcc_far_model u_far (.clk_sys(clk_sys), .srst(srst),
    .issueAllow(issueAllow), .evtReq(evtReq), .respGo(respGo),
    .evt(evt), .pendQ(pendQ));

  // Clock of 20 ns period.
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Counts completion and next-load pulses and cuts a hang short.
  always @(posedge clk_sys) begin
    cycles++;
    if (transferDone === 1'b1) doneCnt++;
    if (loadNext === 1'b1) nextCnt++;
    if (cycles == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("Checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Register write: address and data offered together, each held until taken.
  task automatic wr(logic [11:0] a, logic [31:0] d);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rdw(logic [11:0] a);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd   = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  // One-cycle event request, then time for flags to settle.
  task automatic ev(logic [8:0] e);
    evtReq <= dcc_evt_s'(e);
    @(posedge clk_sys);
    evtReq <= '0;
    tick(2);
  endtask

  initial begin
    srst = 1'b1;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, dbgPause, panicSel, periphSel} = '0;
    evtReq = '0;
    respGo = 1'b1;
    ptr = 32'h0000_1230;
    tick(10);
    srst <= 1'b0;
    tick(1);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("debug reset", {3'h0, DCC_LITE_FLAG, DCC_VERSION, DCC_STATE_RESET,
        BUS_ID, 8'h00}, rd);
    chk("read okay", DCC_RESP_OKAY, resp);
    rdw(DCC_FULL_CS_ADDR);
    chk("cs reset", 32'h0, rd);
    rdw(12'h00C);
    chk("unmapped read", DCC_RESP_SLVERR, resp);
    wr(12'h00C, 32'hFFFF_FFFF);
    chk("unmapped write", DCC_RESP_SLVERR, resp);
    // Read-side error flags: set by a burst, cleared by writing one.
    foreach (EROWS[i]) begin
      ev(EV_STRT);
      ev(EV_RDI);
      repeat (3) ev(EV_BEAT);
      ev(EV_BEAT | EROWS[i].last);
      if (EROWS[i].err != 9'h0) ev(EROWS[i].err);
      rdw(DCC_LITE_DEBUG_ADDR);
      chk("sticky set", EROWS[i].mask, {29'h0, rd[2:0]});
      wr(DCC_LITE_DEBUG_ADDR, 32'h7);
      rdw(DCC_LITE_DEBUG_ADDR);
      chk("sticky clear", 32'h0, {29'h0, rd[2:0]});
    end
    // Outstanding writes fill to the cap while responses stall.
    respGo <= 1'b0;
    ev(EV_STRT);
    repeat (10) ev(EV_WR);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("write count cap", DCC_WR_DEPTH, rd[7:4]);
    rdw(DCC_FULL_CS_ADDR);
    chk("outstanding busy", 2'b11, rd[25:24]);
    respGo <= 1'b1;
    tick(12);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("write count drained", DCC_CNT_RESET, rd[7:4]);
    // Completion waits for the write tally to return to zero.
    wr(DCC_FULL_CS_ADDR, 32'h1000_0000);
    chk("write okay", DCC_RESP_OKAY, resp);
    respGo <= 1'b0;
    ev(EV_STRT);
    ev(EV_WR);
    ev(EV_WR);
    n0 = doneCnt;
    ev(EV_LEN);
    tick(10);
    chk("early done", n0, doneCnt);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("waiting state", 9'(DCC_WAITWR), rd[24:16]);
    respGo <= 1'b1;
    tick(10);
    chk("done after drain", n0 + 1, doneCnt);
    // Debug pause obeyed, then ignored.
    wr(DCC_FULL_CS_ADDR, 32'h0);
    ev(EV_STRT);
    dbgPause <= 1'b1;
    tick(4);
    chk("paused", 1'b0, issueAllow);
    ev(EV_WR);
    chk("no paused issue", 5'h00, pendQ);
    dbgPause <= 1'b0;
    tick(4);
    chk("resumed", 1'b1, issueAllow);
    wr(DCC_FULL_CS_ADDR, 32'h2000_0000);
    dbgPause <= 1'b1;
    tick(4);
    chk("pause ignored", 1'b1, issueAllow);
    dbgPause <= 1'b0;
    // Halt and abort, by software and by error reaction.
    foreach (SROWS[i]) begin
      n0 = nextCnt;
      a0 = descriptorAddr;
      wr(DCC_FULL_CFG_ADDR, {30'h0, SROWS[i].cfg});
      ev(EV_STRT);
      if (SROWS[i].cs != 32'h0) wr(DCC_FULL_CS_ADDR, SROWS[i].cs);
      if (SROWS[i].err != 9'h0) ev(SROWS[i].err);
      for (int k = 0; k < 20 && lenZero !== 1'b1; k++) tick(1);
      chk("length zeroed", 1'b1, lenZero);
      tick(2);
      if (SROWS[i].abt) chk("continues", 1'b1, issueAllow);
      ev(EV_LEN);
      tick(20);
      rdw(DCC_FULL_CS_ADDR);
      chk("self clear", 2'b00, rd[31:30]);
      chk("next loads", SROWS[i].abt, nextCnt - n0);
      if (SROWS[i].abt) begin
        chk("next address", ptr, descriptorAddr);
      end else begin
        chk("stopped", 1'b0, channelActive);
        chk("pointer kept", a0, descriptorAddr);
      end
      wr(DCC_LITE_DEBUG_ADDR, 32'h7);
    end
    wr(DCC_FULL_CFG_ADDR, 32'h0);
    // A halt written while idle clears itself at once.
    wr(DCC_FULL_CS_ADDR, 32'h8000_0000);
    tick(1);
    rdw(DCC_FULL_CS_ADDR);
    chk("idle halt clear", 1'b0, rd[31]);
    // Priority level follows the selected panic line.
    wr(DCC_FULL_CS_ADDR, 32'h0053_0000);
    for (int p = 0; p < 4; p++) begin
      panicSel  <= p[0];
      periphSel <= p[1];
      tick(5);
      chk("qos", (p == 3) ? 4'h5 : 4'h3, axiQos);
    end
    rdw(DCC_FULL_CS_ADDR);
    chk("idle not busy", 1'b0, rd[24]);
    // A new transfer clears a stale write tally.
    respGo <= 1'b0;
    ev(EV_STRT);
    ev(EV_WR);
    ev(EV_WR);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("count before start", 4'h2, rd[7:4]);
    ev(EV_STRT);
    rdw(DCC_LITE_DEBUG_ADDR);
    chk("count cleared", DCC_CNT_RESET, rd[7:4]);
    finish_test();
  end
endmodule
